// ---- common/memmap_defs.svh ----
// constants of the on-chip memory map decoder
//
// Notes on behaviour
// - one linear 16 Mbyte space; byte and word access reach every location except the peripheral windows, which take word access only
// - user mode: four 8K flash blocks at 0-7FFF, 32K at 18000, 64Ks to 4FFFF
// - test flash block hidden in user mode, at address zero in bootstrap
// - low extension RAM E000-E7FF needs global and own enable (bit 2)
// - low extension RAM disabled: range goes to external interface
// - high extension RAM at programmed range needs global and own enable (bit 3)
// - after reset high extension RAM at 90000-93FFF, mirrored every 16K
// - extension RAM: 16-bit, no wait state, byte and word allowed
// - extension RAM never used as system stack, register bank or bit storage; only stack and bit accesses refused, register bank address not checked
// - first CAN window EF00-EFFF needs global enable and bit 0
// - second CAN window EE00-EEFF needs global enable and bit 1
// - clock window ED00-EDFF needs global enable and bit 4
// - extra PWM window EC00-ECFF needs global enable and bit 6
// - second async serial window E900-E9FF needs global enable and bit 7
// - second sync serial window E800-E8FF needs global enable and bit 8
// - I2C window EA00-EAFF needs global enable and bit 9
// - misc window EB00-EBFF needs global enable and bit 10
// - peripheral windows: word only, two wait states, no tristate wait
// - any CAN in use limits segment lines to four, 1 Mbyte external
// - disabled peripheral occupies no address, pins or interrupts
// - flash fetch 32-bit wide; data reads and control area 16-bit
// - register bank: sixteen words, first eight also as byte halves
`ifndef MEMMAP_DEFS_SVH
`define MEMMAP_DEFS_SVH
`define ADDR_W 24
`define FL_LOW_END 24'h00_7FFF
`define FL_MID_BASE 24'h01_8000
`define FL_HIGH_END 24'h04_FFFF
`define FL_CTRL_BASE 24'h08_0000
`define FL_CTRL_END 24'h08_FFFF
`define TEST_FL_END 24'h00_1FFF
`define XRAM_LOW_BASE 24'h00_E000
`define XRAM_LOW_END 24'h00_E7FF
`define XRAM_HIGH_RESET 12'h090
`define XRAM_HIGH_MASK 24'hFF_C000
// mirror span is our choice: the 16K area repeats inside one 64K segment
`define XRAM_HIGH_SPAN_MASK 24'hFF_0000
`define SEG_PAGE_MASK 24'hFF_FF00
`define WIN_CAN1 24'h00_EF00
`define WIN_CAN2 24'h00_EE00
`define WIN_RTC 24'h00_ED00
`define WIN_PWM 24'h00_EC00
`define WIN_ASC 24'h00_E900
`define WIN_SSC 24'h00_E800
`define WIN_I2C 24'h00_EA00
`define WIN_MISC 24'h00_EB00
`define SYS_XBUS_BIT 2
`define EN_XRAM_LOW 2
`define EN_XRAM_HIGH 3
`define EN_CAN1 0
`define EN_CAN2 1
`define EN_RTC 4
`define EN_PWM 6
`define EN_ASC 7
`define EN_SSC 8
`define EN_I2C 9
`define EN_MISC 10
`define XBUS_WAITS 2'h2
`define SEG_LINES_FULL 4'h8
`define SEG_LINES_CAN 4'h4
`define GPR_WORDS 5'h10
`define GPR_BYTE_WORDS 5'h08
`endif

// ---- common/memmap_pkg.sv ----
// types of the on-chip memory map decoder
package memmap_pkg;
  typedef enum logic [3:0] {
    TGT_EXTERNAL, TGT_FLASH, TGT_TEST_FLASH, TGT_FLASH_CTRL, TGT_XRAM_LOW, TGT_XRAM_HIGH,
    TGT_CAN1, TGT_CAN2, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC
  } target_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT} phase_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic byte_access;
    logic [23:0] addr;
    logic [15:0] wdata;
  } cpu_req_t;
  typedef struct packed {
    target_t target;
    logic [23:0] addr;
    logic write;
    logic fetch;
    logic byte_access;
    logic [15:0] wdata;
    logic wide_path;
    logic [1:0] waits;
  } route_t;
endpackage

// ---- logic/region_match.sv ----
// combinational address to target lookup
`timescale 1ns/1ps
`include "memmap_defs.svh"
module region_match
  import memmap_pkg::*;
(
  input wire logic [23:0] addr,
  input wire logic bootstrap,
  input wire logic xbus_on,
  input wire logic [15:0] periph_en,
  input wire logic [11:0] xram_high_seg,
  output target_t target
);
  function automatic logic in_page(input logic [23:0] a, input logic [23:0] base);
    in_page = (a & `SEG_PAGE_MASK) == base;
  endfunction
  logic [23:0] high_base;
  assign high_base = {xram_high_seg, 12'h000} & `XRAM_HIGH_MASK;
  always_comb begin
    target = TGT_EXTERNAL;
    if (bootstrap && addr <= `TEST_FL_END) begin
      target = TGT_TEST_FLASH;
    end else if (addr <= `FL_LOW_END || (addr >= `FL_MID_BASE && addr <= `FL_HIGH_END)) begin
      target = TGT_FLASH;
    end else if (addr >= `FL_CTRL_BASE && addr <= `FL_CTRL_END) begin
      target = TGT_FLASH_CTRL;
    end else if (xbus_on) begin
      // off peripherals fall through, leaving their range unoccupied
      if (periph_en[`EN_XRAM_LOW] && addr >= `XRAM_LOW_BASE && addr <= `XRAM_LOW_END) begin
        target = TGT_XRAM_LOW;
      end else if (periph_en[`EN_XRAM_HIGH] &&
                   (addr & `XRAM_HIGH_SPAN_MASK) == (high_base & `XRAM_HIGH_SPAN_MASK)) begin
        target = TGT_XRAM_HIGH;
      end else if (periph_en[`EN_CAN1] && in_page(addr, `WIN_CAN1)) begin
        target = TGT_CAN1;
      end else if (periph_en[`EN_CAN2] && in_page(addr, `WIN_CAN2)) begin
        target = TGT_CAN2;
      end else if (periph_en[`EN_RTC] && in_page(addr, `WIN_RTC)) begin
        target = TGT_RTC;
      end else if (periph_en[`EN_PWM] && in_page(addr, `WIN_PWM)) begin
        target = TGT_PWM;
      end else if (periph_en[`EN_ASC] && in_page(addr, `WIN_ASC)) begin
        target = TGT_ASC;
      end else if (periph_en[`EN_SSC] && in_page(addr, `WIN_SSC)) begin
        target = TGT_SSC;
      end else if (periph_en[`EN_I2C] && in_page(addr, `WIN_I2C)) begin
        target = TGT_I2C;
      end else if (periph_en[`EN_MISC] && in_page(addr, `WIN_MISC)) begin
        target = TGT_MISC;
      end
    end
  end
endmodule // region_match

// ---- logic/gpr_bank_addr.sv ----
// general register bank address former
`timescale 1ns/1ps
`include "memmap_defs.svh"
module gpr_bank_addr (
  input wire logic [23:0] context_ptr,
  input wire logic [4:0] reg_num,
  input wire logic byte_reg,
  output logic [23:0] gpr_addr,
  output logic gpr_legal
);
  // byte regs 0..15 map to low/high halves of words 0..7
  always_comb begin
    gpr_legal = byte_reg ? (reg_num < (`GPR_BYTE_WORDS << 1)) : (reg_num < `GPR_WORDS);
    if (byte_reg) begin
      gpr_addr = context_ptr + {19'h0, reg_num};
    end else begin
      gpr_addr = context_ptr + {18'h0, reg_num, 1'b0};
    end
  end
endmodule // gpr_bank_addr

// ---- logic/onchip_memory_map_decoder.sv ----
// address decoder and router for the unified on-chip memory map
`timescale 1ns/1ps
`include "memmap_defs.svh"
module onchip_memory_map_decoder
  import memmap_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire cpu_req_t cpu_req,
  input wire logic stack_access,
  input wire logic bit_access,
  input wire logic bootstrap,
  input wire logic [15:0] system_config_reg,
  input wire logic [15:0] xbus_periph_enable_reg,
  input wire logic ext_ram_high_address_write,
  input wire logic [11:0] ext_ram_high_address_data,
  input wire logic [23:0] context_ptr,
  input wire logic [4:0] gpr_num,
  input wire logic gpr_byte,
  output logic cpu_ready,
  output route_t route,
  output logic route_valid,
  output logic access_error,
  output logic [11:0] ext_ram_high_address_reg,
  output logic [3:0] segment_lines,
  output logic [15:0] periph_present,
  output logic [23:0] gpr_addr,
  output logic gpr_legal
);
  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    phase_t phase;
    logic [1:0] wait_cnt;
    route_t route;
    logic route_valid;
    logic access_error;
    logic [11:0] high_seg;
    logic [3:0] seg_lines;
    logic [15:0] present;
  } state_t;
  state_t state, next_state;
  logic xbus_on;
  target_t target;
  logic ext_ram_hit, periph_hit, bad_use;
  assign xbus_on = system_config_reg[`SYS_XBUS_BIT];
  region_match u_match (
    .addr(cpu_req.addr),
    .bootstrap(bootstrap),
    .xbus_on(xbus_on),
    .periph_en(xbus_periph_enable_reg),
    .xram_high_seg(state.high_seg),
    .target(target)
  );
  gpr_bank_addr u_gpr (
    .context_ptr(context_ptr),
    .reg_num(gpr_num),
    .byte_reg(gpr_byte),
    .gpr_addr(gpr_addr),
    .gpr_legal(gpr_legal)
  );
  //////////////////////////////////////////////////////////////////////
  function automatic logic is_periph(input target_t t);
    is_periph = t inside {TGT_CAN1, TGT_CAN2, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC};
  endfunction
  assign ext_ram_hit = target inside {TGT_XRAM_LOW, TGT_XRAM_HIGH};
  assign periph_hit = is_periph(target);
  // extension RAM looks external: no stack or bit storage there; byte to peripheral refused
  assign bad_use = (ext_ram_hit && (stack_access || bit_access)) || (periph_hit && cpu_req.byte_access);
  assign cpu_ready = (state.phase == ST_IDLE);
  always_comb begin
    next_state = state;
    next_state.route_valid = 1'b0;
    next_state.access_error = 1'b0;
    // windows appear only if enabled while global enable is set
    next_state.present = xbus_on ? xbus_periph_enable_reg : 16'h0000;
    next_state.seg_lines = (next_state.present[`EN_CAN1] || next_state.present[`EN_CAN2]) ?
                           `SEG_LINES_CAN : `SEG_LINES_FULL;
    if (ext_ram_high_address_write) begin
      next_state.high_seg = ext_ram_high_address_data;
    end
    case (state.phase)
      ST_IDLE: begin
        if (cpu_req.valid) begin
          if (bad_use) begin
            next_state.access_error = 1'b1;
          end else begin
            next_state.route.target = target;
            next_state.route.addr = cpu_req.addr;
            next_state.route.write = cpu_req.write;
            next_state.route.fetch = cpu_req.fetch;
            next_state.route.byte_access = cpu_req.byte_access;
            next_state.route.wdata = cpu_req.wdata;
            next_state.route.wide_path = cpu_req.fetch && target inside {TGT_FLASH, TGT_TEST_FLASH};
            next_state.route.waits = periph_hit ? `XBUS_WAITS : 2'h0;
            if (periph_hit) begin
              next_state.phase = ST_WAIT;
              next_state.wait_cnt = `XBUS_WAITS;
            end else begin
              next_state.route_valid = 1'b1;
            end
          end
        end
      end
      ST_WAIT: begin
        next_state.wait_cnt = state.wait_cnt - 2'h1;
        if (state.wait_cnt == 2'h1) begin
          next_state.phase = ST_IDLE;
          next_state.route_valid = 1'b1;
        end
      end
      default: begin
        next_state.phase = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.phase <= ST_IDLE;
      state.high_seg <= `XRAM_HIGH_RESET;
      state.seg_lines <= `SEG_LINES_FULL;
    end else if (clk_en) begin
      state <= next_state;
    end
  end
  assign route = state.route;
  assign route_valid = state.route_valid;
  assign access_error = state.access_error;
  assign ext_ram_high_address_reg = state.high_seg;
  assign segment_lines = state.seg_lines;
  assign periph_present = state.present;
  //////////////////////////////////////////////////////////////////////
  sequence s_periph_req;
    cpu_ready && cpu_req.valid && periph_hit && !cpu_req.byte_access && clk_en;
  endsequence
  sequence s_two_waits;
    !cpu_ready [*2];
  endsequence
  a_periph_two_waits: assert property (@(posedge clk) disable iff (!reset_n)
    s_periph_req |=> s_two_waits ##0 (!route_valid) ##1 (route_valid && cpu_ready && route.waits == `XBUS_WAITS))
    else $error("peripheral access not served after two waits");
  a_xram_no_wait: assert property (@(posedge clk) disable iff (!reset_n)
    (cpu_ready && cpu_req.valid && ext_ram_hit && !bad_use && clk_en) |=> (route_valid && route.waits == 2'h0))
    else $error("extension RAM access delayed");
  a_xram_low_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (target == TGT_XRAM_LOW) |-> (xbus_on && xbus_periph_enable_reg[`EN_XRAM_LOW]))
    else $error("low extension RAM decoded while disabled");
  a_xram_low_ext: assert property (@(posedge clk) disable iff (!reset_n)
    (!xbus_on && cpu_req.addr >= `XRAM_LOW_BASE && cpu_req.addr <= `XRAM_LOW_END) |-> target == TGT_EXTERNAL)
    else $error("low extension RAM range not sent external");
  a_can_window: assert property (@(posedge clk) disable iff (!reset_n)
    (target == TGT_CAN1) |-> (xbus_on && xbus_periph_enable_reg[`EN_CAN1] && cpu_req.addr[23:8] == 16'h00EF))
    else $error("first CAN window decoded wrongly");
  a_seg_limit: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && xbus_on && xbus_periph_enable_reg[`EN_CAN2]) |=> segment_lines == `SEG_LINES_CAN)
    else $error("segment lines not limited with CAN in use");
  a_stack_refused: assert property (@(posedge clk) disable iff (!reset_n)
    (cpu_ready && cpu_req.valid && ext_ram_hit && stack_access && clk_en) |=> (access_error && !route_valid))
    else $error("stack access to extension RAM not refused");
  a_test_flash: assert property (@(posedge clk) disable iff (!reset_n)
    (target == TGT_TEST_FLASH) |-> (bootstrap && cpu_req.addr <= `TEST_FL_END))
    else $error("test flash visible outside bootstrap");
  a_hidden_off: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && !xbus_on) |=> periph_present == 16'h0000)
    else $error("peripheral present with global enable clear");
  a_periph_byte_refused: assert property (@(posedge clk) disable iff (!reset_n)
    (cpu_ready && cpu_req.valid && periph_hit && cpu_req.byte_access && clk_en) |=> (access_error && !route_valid))
    else $error("byte access to peripheral window not refused");
  a_xram_high_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (target == TGT_XRAM_HIGH) |-> (xbus_on && xbus_periph_enable_reg[`EN_XRAM_HIGH]))
    else $error("high extension RAM decoded while disabled");
  a_route_forward: assert property (@(posedge clk) disable iff (!reset_n)
    (cpu_ready && cpu_req.valid && !bad_use && clk_en) |=> (route.addr == $past(cpu_req.addr) &&
      route.write == $past(cpu_req.write) && route.byte_access == $past(cpu_req.byte_access)))
    else $error("request not forwarded unchanged");
  a_data_narrow: assert property (@(posedge clk) disable iff (!reset_n)
    (route_valid && !route.fetch) |-> !route.wide_path)
    else $error("data access given the wide path");
  a_seg_full: assert property (@(posedge clk) disable iff (!reset_n)
    (clk_en && !xbus_on) |=> segment_lines == `SEG_LINES_FULL)
    else $error("segment lines limited with global enable clear");
  a_test_hidden: assert property (@(posedge clk) disable iff (!reset_n)
    (!bootstrap && cpu_req.addr <= `TEST_FL_END) |-> target == TGT_FLASH)
    else $error("test flash visible in user mode");
endmodule // onchip_memory_map_decoder

// ---- verification/cpu_bus_model.sv ----
// cpu bus master model driving requests into the decoder
`timescale 1ns/1ps
module cpu_bus_model
  import memmap_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic cpu_ready,
  output cpu_req_t cpu_req,
  output logic stack_access,
  output logic bit_access
);
  initial begin
    cpu_req = '0;
    stack_access = 1'b0;
    bit_access = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // called at a falling edge; ready sampled settled, before the taking edge
  task automatic issue(input cpu_req_t r, input logic st, input logic bt, input int gap);
    logic ok;
    cpu_req_t rel;
    repeat (gap) @(negedge clk);
    cpu_req = r;
    stack_access = st;
    bit_access = bt;
    forever begin
      ok = cpu_ready && clk_en;
      @(posedge clk);
      if (ok) break;
      @(negedge clk);
    end
    @(negedge clk);
    // released lines inverted so a stale value never passes for a live one
    rel = ~r;
    rel.valid = 1'b0;
    cpu_req = rel;
    stack_access = ~st;
    bit_access = ~bt;
  endtask
endmodule // cpu_bus_model

// ---- verification/onchip_memory_map_decoder_tb.sv ----
// self-checking bench of the on-chip memory map decoder
`timescale 1ns/1ps
module onchip_memory_map_decoder_tb;
  import memmap_pkg::*;
  logic clk = 0, reset_n = 0, clk_en = 1, bootstrap = 0, hw = 0, gpr_byte = 0, hmoved = 0;
  logic [15:0] sys = 0, pen = 0, pres;
  logic [11:0] hd = 0, hreg;
  logic [23:0] cptr = 0, gaddr;
  logic [4:0] gnum = 0;
  logic [3:0] seg;
  logic stk, bop, cpu_ready, route_valid, access_error, gpr_legal;
  cpu_req_t req;
  route_t route;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  localparam int win_page [8] = '{8'hEF, 8'hEE, 8'hED, 8'hEC, 8'hE9, 8'hE8, 8'hEA, 8'hEB};
  localparam int win_bit [8] = '{0, 1, 4, 6, 7, 8, 9, 10};
  localparam target_t win_tgt [8] = '{TGT_CAN1, TGT_CAN2, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC};
  localparam int bases [14] = '{24'h00_0000, 24'h00_7F00, 24'h00_8000, 24'h01_8000, 24'h04_FF00, 24'h05_0000,
    24'h08_0000, 24'h00_E000, 24'h00_E700, 24'h09_0000, 24'h09_3F00, 24'h09_4000, 24'h00_E800, 24'h00_1F80};
  initial forever #5 clk = ~clk;
  cpu_bus_model cpu (.clk(clk), .clk_en(clk_en), .cpu_ready(cpu_ready), .cpu_req(req), .stack_access(stk),
    .bit_access(bop));
  onchip_memory_map_decoder uut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cpu_req(req),
    .stack_access(stk), .bit_access(bop), .bootstrap(bootstrap), .system_config_reg(sys),
    .xbus_periph_enable_reg(pen), .ext_ram_high_address_write(hw), .ext_ram_high_address_data(hd),
    .context_ptr(cptr), .gpr_num(gnum), .gpr_byte(gpr_byte), .cpu_ready(cpu_ready), .route(route),
    .route_valid(route_valid), .access_error(access_error), .ext_ram_high_address_reg(hreg),
    .segment_lines(seg), .periph_present(pres), .gpr_addr(gaddr), .gpr_legal(gpr_legal));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // reference map, priority as handed over
  function automatic target_t exp_tgt(int a);
    if (bootstrap && a <= 24'h00_1FFF) return TGT_TEST_FLASH;
    if (a <= 24'h00_7FFF || (a >= 24'h01_8000 && a <= 24'h04_FFFF)) return TGT_FLASH;
    if (a >= 24'h08_0000 && a <= 24'h08_FFFF) return TGT_FLASH_CTRL;
    if (!sys[2]) return TGT_EXTERNAL;
    if (pen[2] && a >= 24'h00_E000 && a <= 24'h00_E7FF) return TGT_XRAM_LOW;
    if (pen[3] && (a >> 16) == (hmoved ? 8'h0A : 8'h09)) return TGT_XRAM_HIGH;
    for (int k = 0; k < 8; k++)
      if ((a >> 8) == win_page[k] && pen[win_bit[k]]) return win_tgt[k];
    return TGT_EXTERNAL;
  endfunction
  task automatic access(int a, logic wr, logic fe, logic by, logic st, logic bt);
    cpu_req_t r;
    target_t t;
    logic err, per;
    int lat;
    r = '{1'b1, wr, fe, by, a[23:0], 16'($urandom)};
    t = exp_tgt(a);
    per = t >= TGT_CAN1;
    err = (per && by) || ((t == TGT_XRAM_LOW || t == TGT_XRAM_HIGH) && (st || bt));
    cpu.issue(r, st, bt, $urandom % 3);
    lat = 1;
    while (!(route_valid === 1'b1 || access_error === 1'b1) && lat < 8) begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk("access_error", access_error, err);
    if (!err) begin
      chk("latency", lat, per ? 3 : 1);
      chk("target", route.target, t);
      chk("addr", route.addr, r.addr);
      chk("kind", {route.write, route.fetch, route.byte_access}, {wr, fe, by});
      chk("wdata", route.wdata, r.wdata);
      chk("waits", route.waits, per ? 2 : 0);
      if (t != TGT_TEST_FLASH) chk("wide_path", route.wide_path, fe && t == TGT_FLASH);
    end
    @(negedge clk);
  endtask
  task automatic do_reset();
    reset_n = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    hmoved = 1'b0;
    chk("reset_flags", {route_valid, access_error, cpu_ready}, 3'h1);
    chk("reset_high_seg", hreg, 12'h090);
    chk("reset_seg", seg, 4'h8);
    chk("reset_present", pres, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(9));
    do_reset();
    $display("reset test done");
    for (int i = 0; i < 200; i++) begin
      sys = 16'($urandom) | 16'($urandom) & 16'h0004;
      pen = 16'($urandom);
      bootstrap = $urandom % 2;
      repeat (2) @(negedge clk);
      chk("segment_lines", seg, (sys[2] && (pen[0] || pen[1])) ? 4'h4 : 4'h8);
      chk("periph_present", pres, sys[2] ? pen : 16'h0000);
      access(bases[$urandom % 14] + $urandom % 256 + ($urandom % 2) * 24'h00_0100 * ($urandom % 8), $urandom % 2,
        $urandom % 2, $urandom % 2, $urandom % 4 == 0, $urandom % 4 == 0);
    end
    $display("map test done");
    for (int n = 0; n < 18; n++) begin
      gnum = n;
      gpr_byte = $urandom % 2;
      cptr = 24'($urandom) & 24'hFF_FFFE;
      #1;
      chk("gpr_legal", gpr_legal, n < 16);
      if (n < 16) chk("gpr_addr", gaddr, 24'(cptr + (gpr_byte ? n : 2 * n)));
      @(negedge clk);
    end
    $display("register bank test done");
    clk_en = 1'b0;
    hw = 1'b1;
    hd = 12'h0A4;
    @(negedge clk);
    hw = 1'b0;
    @(negedge clk);
    chk("high_seg_frozen", hreg, 12'h090);
    clk_en = 1'b1;
    hw = 1'b1;
    @(negedge clk);
    hw = 1'b0;
    @(negedge clk);
    chk("high_seg", hreg, 12'h0A4);
    sys = 16'h0004;
    pen = 16'h0008;
    hmoved = 1'b1;
    repeat (2) @(negedge clk);
    access(24'h09_0000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    access(24'h0A_4000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    do_reset();
    sys = 16'h0004;
    repeat (2) @(negedge clk);
    access(24'h09_2000, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    $display("high area test done");
    wrap_up();
  end
endmodule // onchip_memory_map_decoder_tb
